// ===== include/link_status_pkg.sv
// shared constants for the link status block
package link_status_pkg;
  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_DOWN_COUNT = 12'h008;
  // status register field positions
  localparam int ST_DOWN_BIT = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_WIDTH_LSB = 4;
  localparam int ST_SPEED_LSB = 8;
  // control register fields
  localparam int CTL_CLR_BIT = 0;
  // reset values
  localparam logic RST_LINK_DOWN = 1'b0;
  localparam logic [1:0] RST_STATE = 2'h0;
  localparam logic [3:0] RST_WIDTH = 4'h0;
  localparam logic [2:0] RST_SPEED = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  // link state codes
  localparam logic [1:0] ST_NO_RX = 2'h0;
  localparam logic [1:0] ST_TRAINING = 2'h1;
  localparam logic [1:0] ST_DL_INIT = 2'h2;
  localparam logic [1:0] ST_DL_DONE = 2'h3;
  // speed field values and output codes
  localparam logic [1:0] SPD_FIELD_2G5 = 2'h1;
  localparam logic [1:0] SPD_FIELD_5G0 = 2'h2;
  localparam logic [1:0] SPD_FIELD_8G0 = 2'h3;
  localparam logic [2:0] SPD_2G5 = 3'h1;
  localparam logic [2:0] SPD_5G0 = 3'h2;
  localparam logic [2:0] SPD_8G0 = 3'h4;
  localparam logic [2:0] SPD_NONE = 3'h0;
  // ahb-lite encodings
  localparam logic HRESP_OKAY = 1'b0;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // down event counter
  localparam int DOWN_CNT_W = 16;
endpackage

// ===== design/ahb_word_slave.sv
// ahb-lite slave front end: zero wait state single word access
`timescale 1ns/1ps
`default_nettype none
module ahb_word_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register file side
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data
);
  logic take;
  logic wr_pend;
  logic [11:0] wr_addr_q;
  logic next_wr_pend;
  logic [11:0] next_wr_addr;
  logic [31:0] next_hrdata;

  // address phase accepted
  assign take = hsel && htrans[link_status_pkg::HTRANS_ACT_BIT] && hready;
  assign rd_addr = haddr[11:0];
  assign wr_en = wr_pend;
  assign wr_addr = wr_addr_q;
  assign wr_data = hwdata;

  always_comb begin
    next_wr_pend = take && hwrite && (hsize == link_status_pkg::HSIZE_WORD);
    next_wr_addr = take ? haddr[11:0] : wr_addr_q;
    next_hrdata = (take && !hwrite) ? rd_data : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata <= link_status_pkg::RST_RDATA;
      hreadyout <= 1'b1;
      hresp <= link_status_pkg::HRESP_OKAY;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr_q <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= link_status_pkg::HRESP_OKAY;
    end
  end
endmodule
`default_nettype wire

// ===== design/pcie_link_status.sv
// link status outputs with ahb-lite register view
`timescale 1ns/1ps
`default_nettype none
module pcie_link_status #(
  parameter int WIDTH_W = 4,
  parameter int CNT_W = link_status_pkg::DOWN_CNT_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // physical and data link layer status
  input wire logic phy_rx_detected,
  input wire logic phy_link_up,
  input wire logic dl_init_done,
  input wire logic [WIDTH_W-1:0] lnk_neg_width,
  input wire logic [1:0] lnk_speed_field,
  // status outputs to user logic
  output logic link_down,
  output logic [1:0] link_state,
  output logic [WIDTH_W-1:0] negotiated_width,
  output logic [2:0] current_speed
);
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic link_was_up;
  logic [CNT_W-1:0] down_count;
  logic next_link_down;
  logic [1:0] next_link_state;
  logic [WIDTH_W-1:0] next_width;
  logic [2:0] next_speed;
  logic next_link_was_up;
  logic [CNT_W-1:0] next_down_count;
  logic down_event;
  logic clear_req;

  // link state decode
  function automatic logic [1:0] state_code(input logic rx, input logic up, input logic dl);
    logic [1:0] c;
    c = link_status_pkg::ST_NO_RX;
    if (up) begin
      c = dl ? link_status_pkg::ST_DL_DONE : link_status_pkg::ST_DL_INIT;
    end else if (rx) begin
      c = link_status_pkg::ST_TRAINING;
    end
    return c;
  endfunction

  // speed bits to one-hot rate code
  function automatic logic [2:0] speed_code(input logic [1:0] f);
    logic [2:0] c;
    unique case (f)
      link_status_pkg::SPD_FIELD_2G5: c = link_status_pkg::SPD_2G5;
      link_status_pkg::SPD_FIELD_5G0: c = link_status_pkg::SPD_5G0;
      link_status_pkg::SPD_FIELD_8G0: c = link_status_pkg::SPD_8G0;
      default: c = link_status_pkg::SPD_NONE;
    endcase
    return c;
  endfunction

  ahb_word_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // status outputs
  always_comb begin
    next_link_down = !phy_link_up;
    next_link_state = state_code(phy_rx_detected, phy_link_up, dl_init_done);
    next_width = lnk_neg_width;
    next_speed = speed_code(lnk_speed_field);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_down <= link_status_pkg::RST_LINK_DOWN;
      link_state <= link_status_pkg::RST_STATE;
      negotiated_width <= WIDTH_W'(link_status_pkg::RST_WIDTH);
      current_speed <= link_status_pkg::RST_SPEED;
    end else begin
      link_down <= next_link_down;
      link_state <= next_link_state;
      negotiated_width <= next_width;
      current_speed <= next_speed;
    end
  end

  // link loss counter, cleared from control register
  assign clear_req = wr_en && (wr_addr == link_status_pkg::ADDR_CONTROL) && wr_data[link_status_pkg::CTL_CLR_BIT];
  assign down_event = link_was_up && !phy_link_up;

  always_comb begin
    next_link_was_up = phy_link_up;
    next_down_count = clear_req ? '0 : down_count;
    if (down_event && (next_down_count != '1)) begin
      next_down_count = next_down_count + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_was_up <= 1'b0;
      down_count <= '0;
    end else begin
      link_was_up <= next_link_was_up;
      down_count <= next_down_count;
    end
  end

  // register read mux, unmapped reads give zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      link_status_pkg::ADDR_STATUS: begin
        rd_data[link_status_pkg::ST_DOWN_BIT] = link_down;
        rd_data[link_status_pkg::ST_STATE_LSB +: 2] = link_state;
        rd_data[link_status_pkg::ST_WIDTH_LSB +: WIDTH_W] = negotiated_width;
        rd_data[link_status_pkg::ST_SPEED_LSB +: 3] = current_speed;
      end
      link_status_pkg::ADDR_DOWN_COUNT: begin
        rd_data[CNT_W-1:0] = down_count;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // checks
  AST_DOWN_WHEN_LINK_LOST: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && !phy_link_up |=> link_down)
    else $error("link down flag not set after link loss");

  AST_UP_CLEARS_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_link_up [*2] |-> ##1 !link_down [*1])
    else $error("link down flag set while link is up");

  AST_LOW_IN_RESET: assert property (@(posedge hclk)
    !hresetn |-> !link_down)
    else $error("link down flag high during reset");

  AST_STATE_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (phy_link_up && dl_init_done) |=> (link_state == 2'h3))
    else $error("state code not 11 with dl init complete");

  AST_STATE_DL_INIT: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (phy_link_up && !dl_init_done) |=> (link_state == 2'h2))
    else $error("state code not 10 with dl init running");

  AST_STATE_NO_RX: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (!phy_link_up && !phy_rx_detected) |=> (link_state == 2'h0))
    else $error("state code not 00 without receivers");

  AST_STATE_MATCHES_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> (link_state[1] == !link_down))
    else $error("state code disagrees with link down flag");

  AST_STATE_TRAINING: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (!phy_link_up && phy_rx_detected) |=> (link_state == 2'h1))
    else $error("state code not 01 while training");

  AST_WIDTH_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> (negotiated_width == $past(lnk_neg_width)))
    else $error("negotiated width does not follow field");

  AST_SPEED_8G: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (lnk_speed_field == 2'h3) |=> (current_speed == 3'h4))
    else $error("8.0 GT/s not coded as 100");

  AST_SPEED_5G: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (lnk_speed_field == 2'h2) |=> (current_speed == 3'h2))
    else $error("5.0 GT/s not coded as 010");

  AST_SPEED_ONEHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (lnk_speed_field == 2'h1) |=> (current_speed == 3'h1) && $onehot0(current_speed))
    else $error("speed code malformed");

  AST_COUNT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (clear_req && !down_event) |=> (down_count == '0))
    else $error("link loss counter not cleared");

  AST_COUNT_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && (clear_req && down_event) |=> (down_count == CNT_W'(1)))
    else $error("link loss lost against a clear");

  COV_LINK_READY: cover property (@(posedge hclk) disable iff (!hresetn)
    (link_state == 2'h2) ##[1:20] (link_state == 2'h3));

  COV_LINK_LOSS: cover property (@(posedge hclk) disable iff (!hresetn)
    (link_state == 2'h3) ##1 link_down);

  COV_CLEAR_WITH_EVENT: cover property (@(posedge hclk) disable iff (!hresetn)
    clear_req && down_event);
endmodule
`default_nettype wire

// ===== test/link_user_model.sv
// user side model that trusts the lane count only once the link is fully up
`timescale 1ns/1ps
`default_nettype none
module link_user_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // status from the block
  input wire logic [1:0] link_state,
  input wire logic [3:0] negotiated_width,
  // width as used by the application
  output logic [3:0] used_width
);
  logic [3:0] next_used_width;
  always_comb begin
    next_used_width = used_width;
    if (link_state == 2'h3) begin
      next_used_width = negotiated_width;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      used_width <= 4'h0;
    end else begin
      used_width <= next_used_width;
    end
  end
endmodule
`default_nettype wire

// ===== test/test_pcie_link_status.sv
// self-checking bench for the link status block
`timescale 1ns/1ps
`default_nettype none
module test_pcie_link_status;
  typedef struct packed {
    logic rx; logic up; logic dl; logic [3:0] w; logic [1:0] spd;
    logic down; logic [1:0] state; logic [2:0] code;
  } row_t;
  localparam row_t ROWS [5] = '{
    '{1'h0, 1'h0, 1'h0, 4'h1, 2'h0, 1'h1, 2'h0, 3'h0},
    '{1'h1, 1'h0, 1'h0, 4'h2, 2'h1, 1'h1, 2'h1, 3'h1},
    '{1'h1, 1'h1, 1'h0, 4'h4, 2'h2, 1'h0, 2'h2, 3'h2},
    '{1'h1, 1'h1, 1'h1, 4'h8, 2'h3, 1'h0, 2'h3, 3'h4},
    '{1'h0, 1'h1, 1'h1, 4'hc, 2'h1, 1'h0, 2'h3, 3'h1}};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rx = 1'b0, up = 1'b0, dl = 1'b0;
  logic [3:0] w = 4'h0;
  logic [1:0] spd = 2'h0;
  logic link_down;
  logic [1:0] link_state;
  logic [3:0] negotiated_width;
  logic [2:0] current_speed;
  logic [3:0] used_width;
  logic [31:0] rd;
  int n_mismatch = 0;
  int tests_run = 0;
  pcie_link_status pcie_link_status_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy_rx_detected(rx), .phy_link_up(up),
    .dl_init_done(dl), .lnk_neg_width(w), .lnk_speed_field(spd), .link_down(link_down),
    .link_state(link_state), .negotiated_width(negotiated_width), .current_speed(current_speed));
  link_user_model link_user_model_i (.hclk(hclk), .hresetn(hresetn), .link_state(link_state),
    .negotiated_width(negotiated_width), .used_width(used_width));
  initial begin
    forever #2 hclk = ~hclk;
  end
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    d = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    check({31'h0, link_down}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 check({31'h0, link_down}, 32'h1);
    foreach (ROWS[i]) begin
      @(posedge hclk);
      {rx, up, dl, w, spd} <= {ROWS[i].rx, ROWS[i].up, ROWS[i].dl, ROWS[i].w, ROWS[i].spd};
      @(posedge hclk);
      #1 check({22'h0, link_down, link_state, negotiated_width, current_speed},
               {22'h0, ROWS[i].down, ROWS[i].state, ROWS[i].w, ROWS[i].code});
    end
    @(posedge hclk);
    ahb(1'b0, 32'h0, 3'h2, 32'h0, rd);
    check(rd, {21'h0, 3'h1, 4'hc, 1'h0, 2'h3, 1'h0});
    check({28'h0, used_width}, 32'hc);
    up <= 1'b0;
    w <= 4'h3;
    repeat (3) @(posedge hclk);
    #1 check({28'h0, used_width}, 32'hc);
    check({31'h0, link_down}, 32'h1);
    @(posedge hclk);
    ahb(1'b0, 32'h8, 3'h2, 32'h0, rd);
    check(rd, 32'h1);
    ahb(1'b1, 32'h4, 3'h0, 32'h1, rd);
    ahb(1'b0, 32'h8, 3'h2, 32'h0, rd);
    check(rd, 32'h1);
    ahb(1'b1, 32'h4, 3'h2, 32'h1, rd);
    ahb(1'b0, 32'h8, 3'h2, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b0, 32'h4, 3'h2, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b0, 32'hc, 3'h2, 32'h0, rd);
    check(rd, 32'h0);
    up <= 1'b1;
    @(posedge hclk);
    fork
      ahb(1'b1, 32'h4, 3'h2, 32'h1, rd);
      begin
        @(posedge hclk);
        up <= 1'b0;
      end
    join
    ahb(1'b0, 32'h8, 3'h2, 32'h0, rd);
    check(rd, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 check({26'h0, link_down, link_state, current_speed}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 check({31'h0, link_down}, 32'h1);
    @(posedge hclk);
    ahb(1'b0, 32'h8, 3'h2, 32'h0, rd);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
